// ### common/ocag_pkg.sv
package ocag_pkg;
   localparam int ADDR_W = 16;
   localparam int BUF_N = 4;
   localparam logic [7:0] Y_PFX = 8'h90;
   localparam logic [7:0] IND_PFX = 8'h92;
   localparam logic [7:0] INDY_PFX = 8'h91;
   localparam logic [7:0] PAGE0_HI = 8'h00;
   localparam logic [15:0] IDX_S_MAX = 16'h01FE;
   localparam logic [1:0] MASK_HI = 2'h3;
   localparam logic [1:0] MASK_LO = 2'h0;
   localparam logic [1:0] MASK_RST = 2'h3;
   localparam logic [1:0] MOP_NONE = 2'h0;
   localparam logic [1:0] MOP_SET = 2'h1;
   localparam logic [1:0] MOP_CLR = 2'h2;
   // order fixes the MODE_I encoding, 0 to 16
   typedef enum logic [4:0] {
      M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX_0, M_IDX_S, M_IDX_L,
      M_IND_S, M_IND_L, M_IIX_S, M_IIX_L, M_REL_D, M_REL_I,
      M_BIT_D, M_BIT_I, M_BTR_D, M_BTR_I
   } ocag_mode_t;
   typedef enum logic [1:0] {S_IDLE, S_FETCH, S_CALC} ocag_state_t;
endpackage : ocag_pkg

// ### common/ocag_add_if.sv
`timescale 1ns/1ps
// one address sum: base plus byte offset, zero or sign extended
interface ocag_add_if;
   logic [15:0] base;
   logic [7:0] offs;
   logic sgn;
   logic [15:0] sum;
   modport calc (output base, output offs, output sgn, input sum);
   modport unit (input base, input offs, input sgn, output sum);
endinterface : ocag_add_if

// ### hdl/ocag_sum.sv
`timescale 1ns/1ps
module ocag_sum (
   ocag_add_if.unit a
);
   logic [15:0] ext;
   // unsigned index or signed branch offset
   assign ext = {{8{a.sgn & a.offs[7]}}, a.offs};
   // carry out of bit 15 dropped on purpose
   assign a.sum = a.base + ext;
endmodule : ocag_sum

// ### hdl/ocag_core.sv
`timescale 1ns/1ps
module ocag_core #(
   parameter int ADDR_W = ocag_pkg::ADDR_W
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   input wire logic START_I,
   input wire logic [4:0] MODE_I,
   input wire logic [7:0] PREFIX_I,
   input wire logic RMW_I,
   input wire logic [1:0] MASK_OP_I,
   input wire logic [7:0] X_I,
   input wire logic [7:0] Y_I,
   input wire logic [ADDR_W-1:0] OPC_ADDR_I,
   output logic MEM_RD_O,
   output logic [ADDR_W-1:0] MEM_ADDR_O,
   input wire logic [7:0] MEM_DATA_I,
   input wire logic MEM_ACK_I,
   output logic BUSY_O,
   output logic DONE_O,
   output logic ILLEGAL_O,
   output logic [ADDR_W-1:0] EA_O,
   output logic [ADDR_W-1:0] TGT_O,
   output logic [7:0] IMM_O,
   output logic [2:0] LEN_O,
   output logic [1:0] MASK_O
);
   generate
      if (ADDR_W != 16) begin : g_bad_width
         $error("ocag_core serves a 16-bit address only");
      end
   endgenerate

   // operand bytes that follow the opcode
   function automatic logic [2:0] n_ops(ocag_pkg::ocag_mode_t m);
      case (m)
         ocag_pkg::M_INH, ocag_pkg::M_IDX_0: n_ops = 3'h0;
         ocag_pkg::M_DIR_L, ocag_pkg::M_IDX_L: n_ops = 3'h2;
         ocag_pkg::M_BTR_D, ocag_pkg::M_BTR_I: n_ops = 3'h2;
         default: n_ops = 3'h1;
      endcase
   endfunction : n_ops

   // pointer bytes read from page zero
   function automatic logic [2:0] n_ptr(ocag_pkg::ocag_mode_t m);
      case (m)
         ocag_pkg::M_IND_L, ocag_pkg::M_IIX_L: n_ptr = 3'h2;
         ocag_pkg::M_IND_S, ocag_pkg::M_IIX_S, ocag_pkg::M_REL_I: n_ptr = 3'h1;
         ocag_pkg::M_BIT_I, ocag_pkg::M_BTR_I: n_ptr = 3'h1;
         default: n_ptr = 3'h0;
      endcase
   endfunction : n_ptr

   function automatic logic is_long(ocag_pkg::ocag_mode_t m);
      case (m)
         ocag_pkg::M_DIR_L, ocag_pkg::M_IDX_L: is_long = 1'b1;
         ocag_pkg::M_IND_L, ocag_pkg::M_IIX_L: is_long = 1'b1;
         default: is_long = 1'b0;
      endcase
   endfunction : is_long

   // prefix rewrites the base mode of the opcode
   function automatic ocag_pkg::ocag_mode_t map_mode(ocag_pkg::ocag_mode_t m, logic [7:0] p);
      map_mode = m;
      if (p == ocag_pkg::IND_PFX) begin
         case (m)
            ocag_pkg::M_DIR_S: map_mode = ocag_pkg::M_IND_S;
            ocag_pkg::M_DIR_L: map_mode = ocag_pkg::M_IND_L;
            ocag_pkg::M_BIT_D: map_mode = ocag_pkg::M_BIT_I;
            ocag_pkg::M_BTR_D: map_mode = ocag_pkg::M_BTR_I;
            ocag_pkg::M_REL_D: map_mode = ocag_pkg::M_REL_I;
            ocag_pkg::M_IDX_S: map_mode = ocag_pkg::M_IIX_S;
            ocag_pkg::M_IDX_L: map_mode = ocag_pkg::M_IIX_L;
            default: map_mode = m;
         endcase
      end else if (p == ocag_pkg::INDY_PFX) begin
         case (m)
            ocag_pkg::M_IDX_S: map_mode = ocag_pkg::M_IIX_S;
            ocag_pkg::M_IDX_L: map_mode = ocag_pkg::M_IIX_L;
            default: map_mode = m;
         endcase
      end
   endfunction : map_mode

   ocag_pkg::ocag_state_t st_q;
   ocag_pkg::ocag_mode_t mode_q;
   ocag_pkg::ocag_mode_t start_mode;
   logic [7:0] buf_q [0:ocag_pkg::BUF_N-1];
   logic [7:0] idx_q;
   logic [15:0] opc_q;
   logic [2:0] step_q;
   logic [1:0] mop_q;
   logic pfx_q;
   logic rmw_q;
   logic bad_q;
   logic start_ok;
   logic start_bad;
   logic start_pfx;
   logic [2:0] start_tot;
   logic [2:0] nops;
   logic [2:0] total;
   logic last;
   logic [7:0] b0_now;
   logic [2:0] s_nx;
   logic [15:0] nxt_addr;
   logic [7:0] p0;
   logic [7:0] p1;
   logic [15:0] nxt_pc;
   ocag_add_if ea_if ();
   ocag_add_if tg_if ();

   // decode of a request: 17 modes, codes above 16 refused
   assign start_ok = (st_q == ocag_pkg::S_IDLE) && START_I;
   assign start_mode = map_mode(ocag_pkg::ocag_mode_t'(MODE_I), PREFIX_I);
   assign start_pfx = (PREFIX_I == ocag_pkg::Y_PFX) || (PREFIX_I == ocag_pkg::IND_PFX)
                      || (PREFIX_I == ocag_pkg::INDY_PFX);
   // long forms on memory read-modify-write are flagged, never fetched
   assign start_bad = (MODE_I > 5'(ocag_pkg::M_BTR_I)) || (RMW_I && is_long(start_mode));
   assign start_tot = n_ops(start_mode) + n_ptr(start_mode);

   // fetch sequencing
   assign nops = n_ops(mode_q);
   assign total = nops + n_ptr(mode_q);
   assign last = (step_q == total - 3'h1);
   assign b0_now = (step_q == 3'h0) ? MEM_DATA_I : buf_q[0];
   assign s_nx = step_q + 3'h1;
   // pointer wraps inside page zero, never leaves it
   always_comb begin
      if (s_nx < nops) begin
         nxt_addr = opc_q + 16'h0001 + {13'h0000, s_nx};
      end else begin
         nxt_addr = {ocag_pkg::PAGE0_HI, b0_now + {5'h00, s_nx - nops}};
      end
   end

   // pointer bytes sit right after the operand bytes, high byte first
   assign p0 = buf_q[nops[1:0]];
   assign p1 = buf_q[nops[1:0] + 2'h1];
   assign nxt_pc = opc_q + 16'h0001 + {13'h0000, nops};

   // effective address sum
   always_comb begin
      ea_if.base = 16'h0000;
      ea_if.offs = 8'h00;
      ea_if.sgn = 1'b0;
      case (mode_q)
         ocag_pkg::M_DIR_S, ocag_pkg::M_BIT_D, ocag_pkg::M_BTR_D: begin
            ea_if.base = {ocag_pkg::PAGE0_HI, buf_q[0]};
         end
         ocag_pkg::M_DIR_L: begin
            ea_if.base = {buf_q[0], buf_q[1]};
         end
         ocag_pkg::M_IDX_0: begin
            ea_if.offs = idx_q;
         end
         ocag_pkg::M_IDX_S: begin
            ea_if.base = {ocag_pkg::PAGE0_HI, buf_q[0]};
            ea_if.offs = idx_q;
         end
         ocag_pkg::M_IDX_L: begin
            ea_if.base = {buf_q[0], buf_q[1]};
            ea_if.offs = idx_q;
         end
         ocag_pkg::M_IND_S, ocag_pkg::M_BIT_I, ocag_pkg::M_BTR_I: begin
            ea_if.base = {ocag_pkg::PAGE0_HI, p0};
         end
         ocag_pkg::M_IND_L: begin
            ea_if.base = {p0, p1};
         end
         ocag_pkg::M_IIX_S: begin
            ea_if.base = {ocag_pkg::PAGE0_HI, p0};
            ea_if.offs = idx_q;
         end
         ocag_pkg::M_IIX_L: begin
            ea_if.base = {p0, p1};
            ea_if.offs = idx_q;
         end
         default: begin
            ea_if.base = 16'h0000;
         end
      endcase
   end

   // branch target: next instruction plus signed offset
   always_comb begin
      tg_if.base = nxt_pc;
      tg_if.sgn = 1'b1;
      case (mode_q)
         ocag_pkg::M_REL_D: tg_if.offs = buf_q[0];
         ocag_pkg::M_REL_I: tg_if.offs = p0;
         ocag_pkg::M_BTR_D, ocag_pkg::M_BTR_I: tg_if.offs = buf_q[1];
         default: tg_if.offs = 8'h00;
      endcase
   end

   ocag_sum u_ea (
      .a(ea_if)
   );
   ocag_sum u_tg (
      .a(tg_if)
   );

   // request capture and state
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         st_q <= ocag_pkg::S_IDLE;
         mode_q <= ocag_pkg::M_INH;
         idx_q <= 8'h00;
         opc_q <= 16'h0000;
         step_q <= 3'h0;
         mop_q <= ocag_pkg::MOP_NONE;
         pfx_q <= 1'b0;
         rmw_q <= 1'b0;
         bad_q <= 1'b0;
      end else if (CE_I) begin
         case (st_q)
            ocag_pkg::S_IDLE: begin
               if (start_ok) begin
                  mode_q <= start_mode;
                  // Y for 90 and 91, X otherwise
                  idx_q <= (PREFIX_I == ocag_pkg::Y_PFX || PREFIX_I == ocag_pkg::INDY_PFX)
                           ? Y_I : X_I;
                  opc_q <= OPC_ADDR_I;
                  step_q <= 3'h0;
                  mop_q <= MASK_OP_I;
                  pfx_q <= start_pfx;
                  rmw_q <= RMW_I;
                  bad_q <= start_bad;
                  if (start_bad || start_tot == 3'h0) begin
                     st_q <= ocag_pkg::S_CALC;
                  end else begin
                     st_q <= ocag_pkg::S_FETCH;
                  end
               end
            end
            ocag_pkg::S_FETCH: begin
               if (MEM_ACK_I) begin
                  step_q <= s_nx;
                  if (last) begin
                     st_q <= ocag_pkg::S_CALC;
                  end
               end
            end
            ocag_pkg::S_CALC: begin
               st_q <= ocag_pkg::S_IDLE;
            end
            default: begin
               st_q <= ocag_pkg::S_IDLE;
            end
         endcase
      end
   end

   // fetched bytes, stored in arrival order
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         for (int i = 0; i < ocag_pkg::BUF_N; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else if (CE_I && st_q == ocag_pkg::S_FETCH && MEM_ACK_I) begin
         buf_q[step_q[1:0]] <= MEM_DATA_I;
      end
   end

   // memory read port: request holds with a steady address until ack
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         MEM_RD_O <= 1'b0;
         MEM_ADDR_O <= 16'h0000;
      end else if (CE_I) begin
         if (start_ok && !start_bad && start_tot != 3'h0) begin
            MEM_RD_O <= 1'b1;
            MEM_ADDR_O <= OPC_ADDR_I + 16'h0001;
         end else if (MEM_RD_O && MEM_ACK_I) begin
            if (last) begin
               MEM_RD_O <= 1'b0;
            end else begin
               MEM_ADDR_O <= nxt_addr;
            end
         end
      end
   end

   // results, latched as the sequence ends
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         DONE_O <= 1'b0;
         ILLEGAL_O <= 1'b0;
         EA_O <= 16'h0000;
         TGT_O <= 16'h0000;
         IMM_O <= 8'h00;
         LEN_O <= 3'h0;
         BUSY_O <= 1'b0;
      end else if (CE_I) begin
         DONE_O <= (st_q == ocag_pkg::S_CALC);
         BUSY_O <= start_ok || (st_q == ocag_pkg::S_FETCH && !(MEM_ACK_I && last));
         if (st_q == ocag_pkg::S_CALC) begin
            ILLEGAL_O <= bad_q;
            EA_O <= bad_q ? 16'h0000 : ea_if.sum;
            TGT_O <= tg_if.sum;
            IMM_O <= (mode_q == ocag_pkg::M_IMM) ? buf_q[0] : 8'h00;
            // optional prefix, opcode, then the operand bytes
            LEN_O <= 3'h1 + {2'b00, pfx_q} + nops;
         end
      end
   end

   // interrupt mask level, changed only by valid inherent ops
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         MASK_O <= ocag_pkg::MASK_RST;
      end else if (CE_I && st_q == ocag_pkg::S_CALC && !bad_q && mode_q == ocag_pkg::M_INH) begin
         if (mop_q == ocag_pkg::MOP_SET) begin
            MASK_O <= ocag_pkg::MASK_HI;
         end else if (mop_q == ocag_pkg::MOP_CLR) begin
            MASK_O <= ocag_pkg::MASK_LO;
         end
      end
   end

   chk_inh_len: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      DONE_O && !ILLEGAL_O && mode_q == ocag_pkg::M_INH |-> LEN_O == (pfx_q ? 3'h2 : 3'h1))
      else $error("inherent length wrong");
   chk_imm_data: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      DONE_O && mode_q == ocag_pkg::M_IMM && !pfx_q |-> LEN_O == 3'h2 && IMM_O == buf_q[0])
      else $error("immediate operand wrong");
   chk_dir_page: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      DONE_O && mode_q == ocag_pkg::M_DIR_S |-> EA_O[15:8] == ocag_pkg::PAGE0_HI)
      else $error("short direct left page zero");
   chk_idx_span: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      DONE_O && (mode_q == ocag_pkg::M_IDX_S || mode_q == ocag_pkg::M_IIX_S)
      |-> EA_O <= ocag_pkg::IDX_S_MAX)
      else $error("short indexed above 1FE");
   chk_idx_zero: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      DONE_O && !ILLEGAL_O && mode_q == ocag_pkg::M_IDX_0 |-> EA_O == {8'h00, idx_q})
      else $error("no-offset indexed address wrong");
   chk_long_rmw: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      DONE_O && rmw_q && is_long(mode_q) |-> ILLEGAL_O && EA_O == 16'h0000)
      else $error("long form accepted for rmw");
   chk_mask_set: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      DONE_O && !ILLEGAL_O && mode_q == ocag_pkg::M_INH && mop_q == ocag_pkg::MOP_SET
      |-> MASK_O == ocag_pkg::MASK_HI)
      else $error("mask set level wrong");
   chk_ptr_page: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      MEM_RD_O && step_q >= nops |-> MEM_ADDR_O[15:8] == ocag_pkg::PAGE0_HI)
      else $error("pointer read outside page zero");
   chk_rd_hold: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      MEM_RD_O && !MEM_ACK_I && CE_I |=> MEM_RD_O && $stable(MEM_ADDR_O))
      else $error("read dropped before ack");
endmodule : ocag_core

// ### tb/ocag_mem_model.sv
`timescale 1ns/1ps
// program and data memory behind the read port, answering after dly_i stall cycles
module ocag_mem_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rd_i,
   input wire logic [15:0] addr_i,
   input wire logic [3:0] dly_i,
   output logic [7:0] data_o,
   output logic ack_o
);
   logic [7:0] cells [65536];
   logic [7:0] last_q;
   int wait_q;
   // background pattern so no cell reads as unknown
   initial begin
      foreach (cells[i]) cells[i] = 8'(i);
   end
   // ack only while a read is asked for
   assign ack_o = rd_i && (wait_q >= int'(dly_i));
   // junk outside the ack cycle, so a late sample never sees a stale byte
   assign data_o = ack_o ? cells[addr_i] : ~last_q;
   // stall count of the byte in flight
   always_ff @(posedge clk_i) begin
      if (rst_i || !rd_i || ack_o) wait_q <= 0;
      else wait_q <= wait_q + 1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) last_q <= 8'h5A;
      else if (ack_o) last_q <= data_o;
   end
endmodule : ocag_mem_model

// ### tb/cpu_operand_address_generator_bench.sv
`timescale 1ns/1ps
module cpu_operand_address_generator_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic ce = 1'b1;
   logic rmw = 1'b0;
   logic r_sel = 1'b0;
   logic [4:0] mode = 5'h00;
   logic [7:0] pfx = 8'h00;
   logic [1:0] mop = 2'h0;
   logic [1:0] k_sel = 2'h0;
   logic [7:0] xr = 8'h00;
   logic [7:0] yr = 8'h00;
   logic [15:0] opc_a = 16'h1000;
   logic [15:0] opc = 16'h1000;
   logic [3:0] dly = 4'h0;
   logic rd, ack, done, busy, ill;
   logic [7:0] rdat, imm;
   logic [15:0] maddr, ea, tgt;
   logic [2:0] len;
   logic [1:0] mask;
   int num_errors = 0;
   int check_count = 0;
   int rd_cnt = 0;

   always #5 clk = ~clk;

   ocag_core #(.ADDR_W(16)) dut (
      .CLK_I(clk), .RST_I(rst), .CE_I(ce), .START_I(start), .MODE_I(mode),
      .PREFIX_I(pfx), .RMW_I(rmw), .MASK_OP_I(mop), .X_I(xr), .Y_I(yr),
      .OPC_ADDR_I(opc_a), .MEM_RD_O(rd), .MEM_ADDR_O(maddr), .MEM_DATA_I(rdat),
      .MEM_ACK_I(ack), .BUSY_O(busy), .DONE_O(done), .ILLEGAL_O(ill), .EA_O(ea),
      .TGT_O(tgt), .IMM_O(imm), .LEN_O(len), .MASK_O(mask));

   ocag_mem_model mem (.clk_i(clk), .rst_i(rst), .rd_i(rd), .addr_i(maddr),
      .dly_i(dly), .data_o(rdat), .ack_o(ack));

   // read cycles seen, to prove refused requests stay off the bus
   always @(posedge clk) begin
      if (rd === 1'b1) rd_cnt++;
   end

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask : chk

   task automatic mw(input logic [15:0] a, input logic [7:0] v);
      mem.cells[a] = v;
   endtask : mw

   // one request, then a bounded wait for the done pulse
   task automatic go(input logic [4:0] m, input logic [7:0] p, input logic [7:0] x, input logic [7:0] y);
      int n;
      @(posedge clk);
      mode <= m;
      pfx <= p;
      rmw <= r_sel;
      mop <= k_sel;
      xr <= x;
      yr <= y;
      opc_a <= opc;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(negedge clk);
      chk("BUSY_O", 16'h0001, 16'(busy));
      n = 1;
      while (done !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk("DONE_O", 16'h0001, 16'(done));
      chk("BUSY_O", 16'h0000, 16'(busy));
   endtask : go

   task automatic ex(input logic [15:0] e, input logic [15:0] t, input logic [2:0] l, input logic i);
      chk("EA_O", e, ea);
      chk("TGT_O", t, tgt);
      chk("LEN_O", 16'(l), 16'(len));
      chk("ILLEGAL_O", 16'(i), 16'(ill));
   endtask : ex

   task automatic t_inherent;
      rd_cnt = 0;
      k_sel = ocag_pkg::MOP_CLR;
      go(ocag_pkg::M_INH, 8'h00, 8'h00, 8'h00);
      ex(16'h0000, 16'h1001, 3'h1, 1'b0);
      chk("MASK_O", 16'h0000, 16'(mask));
      k_sel = ocag_pkg::MOP_SET;
      go(ocag_pkg::M_INH, 8'h00, 8'h00, 8'h00);
      chk("MASK_O", 16'h0003, 16'(mask));
      k_sel = ocag_pkg::MOP_NONE;
      go(ocag_pkg::M_INH, 8'h90, 8'h00, 8'h00);
      ex(16'h0000, 16'h1001, 3'h2, 1'b0);
      chk("reads", 16'h0000, 16'(rd_cnt));
      mw(16'h1001, 8'h55);
      go(ocag_pkg::M_IMM, 8'h00, 8'h00, 8'h00);
      ex(16'h0000, 16'h1002, 3'h2, 1'b0);
      chk("IMM_O", 16'h0055, 16'(imm));
      $display("test inherent and immediate done");
   endtask : t_inherent

   // clock enable low: a request is never taken and the mask holds
   task automatic t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      mode <= ocag_pkg::M_INH;
      pfx <= 8'h00;
      mop <= ocag_pkg::MOP_CLR;
      start <= 1'b1;
      repeat (4) @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      ce <= 1'b1;
      repeat (2) @(negedge clk);
      chk("BUSY_O", 16'h0000, 16'(busy));
      chk("DONE_O", 16'h0000, 16'(done));
      chk("MASK_O", 16'h0003, 16'(mask));
      $display("test clock enable done");
   endtask : t_freeze

   // slow memory here, so every byte waits out a stall
   task automatic t_direct;
      dly = 4'h3;
      mw(16'h1001, 8'h80);
      go(ocag_pkg::M_DIR_S, 8'h00, 8'h00, 8'h00);
      ex(16'h0080, 16'h1002, 3'h2, 1'b0);
      mw(16'h1001, 8'h12);
      mw(16'h1002, 8'h34);
      go(ocag_pkg::M_DIR_L, 8'h00, 8'h00, 8'h00);
      ex(16'h1234, 16'h1003, 3'h3, 1'b0);
      dly = 4'h0;
      $display("test direct done");
   endtask : t_direct

   task automatic t_indexed;
      go(ocag_pkg::M_IDX_0, 8'h00, 8'hF7, 8'h00);
      ex(16'h00F7, 16'h1001, 3'h1, 1'b0);
      mw(16'h1001, 8'hFF);
      go(ocag_pkg::M_IDX_S, 8'h00, 8'hFF, 8'h00);
      ex(16'h01FE, 16'h1002, 3'h2, 1'b0);
      mw(16'h1002, 8'hF0);
      go(ocag_pkg::M_IDX_L, 8'h00, 8'h20, 8'h00);
      ex(16'h0010, 16'h1003, 3'h3, 1'b0);
      mw(16'h1001, 8'h10);
      go(ocag_pkg::M_IDX_S, 8'h90, 8'h01, 8'h33);
      ex(16'h0043, 16'h1002, 3'h3, 1'b0);
      $display("test indexed done");
   endtask : t_indexed

   task automatic t_indirect;
      dly = 4'h1;
      mw(16'h1001, 8'h40);
      mw(16'h0040, 8'h9A);
      go(ocag_pkg::M_IND_S, 8'h00, 8'h00, 8'h00);
      ex(16'h009A, 16'h1002, 3'h2, 1'b0);
      go(ocag_pkg::M_DIR_S, 8'h92, 8'h00, 8'h00);
      ex(16'h009A, 16'h1002, 3'h3, 1'b0);
      mw(16'h1001, 8'hFF);
      mw(16'h00FF, 8'hAB);
      mw(16'h0000, 8'hCD);
      go(ocag_pkg::M_IND_L, 8'h00, 8'h00, 8'h00);
      ex(16'hABCD, 16'h1002, 3'h2, 1'b0);
      mw(16'h1001, 8'h50);
      mw(16'h0050, 8'hF0);
      go(ocag_pkg::M_IIX_S, 8'h00, 8'h0E, 8'h00);
      ex(16'h00FE, 16'h1002, 3'h2, 1'b0);
      go(ocag_pkg::M_IDX_S, 8'h92, 8'h0E, 8'h01);
      ex(16'h00FE, 16'h1002, 3'h3, 1'b0);
      go(ocag_pkg::M_IDX_S, 8'h91, 8'h0E, 8'h05);
      ex(16'h00F5, 16'h1002, 3'h3, 1'b0);
      mw(16'h0050, 8'hFF);
      mw(16'h0051, 8'hFF);
      go(ocag_pkg::M_IIX_L, 8'h00, 8'h02, 8'h00);
      ex(16'h0001, 16'h1002, 3'h2, 1'b0);
      dly = 4'h0;
      $display("test indirect done");
   endtask : t_indirect

   // targets counted from the byte after the whole instruction
   task automatic t_relative;
      opc = 16'h2000;
      mw(16'h2001, 8'hFE);
      go(ocag_pkg::M_REL_D, 8'h00, 8'h00, 8'h00);
      ex(16'h0000, 16'h2000, 3'h2, 1'b0);
      mw(16'h2001, 8'h7F);
      go(ocag_pkg::M_REL_D, 8'h00, 8'h00, 8'h00);
      ex(16'h0000, 16'h2081, 3'h2, 1'b0);
      mw(16'h2001, 8'h30);
      mw(16'h0030, 8'h80);
      go(ocag_pkg::M_REL_D, 8'h92, 8'h00, 8'h00);
      ex(16'h0000, 16'h1F82, 3'h3, 1'b0);
      mw(16'h2001, 8'h44);
      mw(16'h2002, 8'h03);
      go(ocag_pkg::M_BTR_D, 8'h00, 8'h00, 8'h00);
      ex(16'h0044, 16'h2006, 3'h3, 1'b0);
      go(ocag_pkg::M_BIT_D, 8'h00, 8'h00, 8'h00);
      ex(16'h0044, 16'h2002, 3'h2, 1'b0);
      mw(16'h0044, 8'h66);
      go(ocag_pkg::M_BIT_D, 8'h92, 8'h00, 8'h00);
      ex(16'h0066, 16'h2002, 3'h3, 1'b0);
      go(ocag_pkg::M_BTR_D, 8'h92, 8'h00, 8'h00);
      ex(16'h0066, 16'h2006, 3'h4, 1'b0);
      opc = 16'h1000;
      $display("test relative done");
   endtask : t_relative

   // every defined mode accepted, undefined codes and the long direct form on memory refused
   task automatic t_modes;
      for (int m = 0; m < 17; m++) begin
         go(5'(m), 8'h00, 8'h03, 8'h04);
         chk("ILLEGAL_O", 16'h0000, 16'(ill));
      end
      rd_cnt = 0;
      go(5'h11, 8'h00, 8'h00, 8'h00);
      chk("ILLEGAL_O", 16'h0001, 16'(ill));
      go(5'h1F, 8'h00, 8'h00, 8'h00);
      chk("ILLEGAL_O", 16'h0001, 16'(ill));
      r_sel = 1'b1;
      go(ocag_pkg::M_DIR_L, 8'h00, 8'h00, 8'h00);
      chk("ILLEGAL_O", 16'h0001, 16'(ill));
      chk("EA_O", 16'h0000, ea);
      chk("reads", 16'h0000, 16'(rd_cnt));
      mw(16'h1001, 8'h80);
      go(ocag_pkg::M_DIR_S, 8'h00, 8'h00, 8'h00);
      ex(16'h0080, 16'h1002, 3'h2, 1'b0);
      r_sel = 1'b0;
      $display("test modes done");
   endtask : t_modes

   task automatic results;
      $display("checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results

   // watchdog, well past the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      $display("unexpected timeout: expected done, seen hang");
      results();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("MASK_O", 16'h0003, 16'(mask));
      chk("BUSY_O", 16'h0000, 16'(busy));
      chk("MEM_RD_O", 16'h0000, 16'(rd));
      t_inherent();
      t_freeze();
      t_direct();
      t_indexed();
      t_indirect();
      t_relative();
      t_modes();
      results();
   end
endmodule : cpu_operand_address_generator_bench
